// ===== pkg/smsp_link_if.sv
// Purpose: two-wire link joining master and slave ends
// Assumes: master drives the clock push-pull, data is open drain
// Notes: wired-AND of both data drivers forms the line level
`timescale 1ns/1ps

interface smsp_link_if;
	logic scl;
	logic m_sda_o;
	logic m_sda_oe_n;
	logic s_sda_o;
	logic s_sda_oe_n;
	logic sda_line;

	// Released driver floats high through the pull-up
	assign sda_line = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

	modport master (
		output scl,
		output m_sda_o,
		output m_sda_oe_n,
		input sda_line
	);

	modport slave (
		input scl,
		output s_sda_o,
		output s_sda_oe_n,
		input sda_line
	);
endinterface

// ===== pkg/smsp_pkg.sv
// Purpose: types shared by both ends of the serial memory port
// Assumes: smsp_regs.svh on the include path
// Notes: each end keeps its state in one struct from here, the slave's memory array aside
`include "smsp_regs.svh"

package smsp_pkg;

	// ----------------------------------------
	// Slave end
	// ----------------------------------------
	typedef enum logic [2:0] {
		SMSP_S_IDLE = 3'b000,
		SMSP_S_RX = 3'b001,
		SMSP_S_RX_ACK = 3'b011,
		SMSP_S_TX = 3'b010,
		SMSP_S_TX_ACK = 3'b110
	} smsp_sst_t;

	typedef enum logic [1:0] {
		SMSP_K_DEV = 2'b00,
		SMSP_K_MADDR = 2'b01,
		SMSP_K_DATA = 2'b11
	} smsp_kind_t;

	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_s3;
		logic sda_s1;
		logic sda_s2;
		logic sda_s3;
		logic [2:0] sel_s1;
		logic [2:0] sel_s2;
		smsp_sst_t st;
		smsp_kind_t kind;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic rw;
		logic mack;
		logic [7:0] addr;
		logic [`SMSP_ROW_W-1:0] wrow;
		logic [7:0][7:0] row_buf;
		logic dirty;
		logic [15:0] busy_cnt;
		logic commit;
		logic busy;
		logic sda_oe_n;
		logic [7:0] cfg_rdata;
	} smsp_slv_t;

	// ----------------------------------------
	// Master end
	// ----------------------------------------
	typedef enum logic [3:0] {
		SMSP_M_IDLE = 4'b0000,
		SMSP_M_START = 4'b0001,
		SMSP_M_DEV = 4'b0011,
		SMSP_M_MADDR = 4'b0010,
		SMSP_M_WDATA = 4'b0110,
		SMSP_M_RSTART = 4'b0111,
		SMSP_M_DEVR = 4'b0101,
		SMSP_M_RDATA = 4'b0100,
		SMSP_M_STOP = 4'b1100
	} smsp_mst_t;

	typedef struct packed {
		logic [7:0] q;
		smsp_mst_t step;
		logic [1:0] ph;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic ack;
		logic loaded;
		logic [3:0] left;
		logic rd;
		logic set_addr;
		logic [2:0] sel;
		logic [7:0] addr;
		logic sda_s1;
		logic sda_s2;
		logic scl;
		logic sda_oe_n;
		logic cmd_ready;
		logic wr_ready;
		logic done;
		logic nack_err;
		logic [1:0][7:0] rbuf;
		logic rwp;
		logic rrp;
		logic [1:0] rcnt;
		logic rd_valid;
		logic [7:0] rd_data;
	} smsp_mst_state_t;

endpackage

// ===== pkg/smsp_regs.svh
// Purpose: shared constants of the two-wire serial memory slave port
// Assumes: core clock of 50 MHz on both ends
// Notes: figures only; types live in smsp_pkg
// How it works
// - Master acks every read byte wanting more
// - Master nacks final byte, then stops
// - Reads start at counter, advance per byte
// - Every byte travels most significant bit first
// - First byte after start: address plus direction
// - Slave address is 1010 plus select pins
// - Single write: start, address, offset, data, stop
// - One write carries at most one 8-byte row
// - Random read: dummy write, repeated start, nack
// - Multi-byte random read acks all but last
// - Slave drives only its acks and read data
// - Write counter wraps inside current eight-byte row
// - No address ack while committing a row
// - Foreign address ignored until next start
// - Commit rewrites whole row, untouched bytes kept
`ifndef SMSP_REGS_SVH
`define SMSP_REGS_SVH

// ----------------------------------------
// Addressing
// ----------------------------------------
`define SMSP_DEV_CODE 4'h0a
`define SMSP_ADDR_W 8
`define SMSP_ROW_W 5
`define SMSP_ROW_BYTES 8
`define SMSP_RD_LAST_MAX 4'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define SMSP_CLK_MHZ 50
`define SMSP_TW_US 5
`define SMSP_TW_CYC (`SMSP_TW_US * `SMSP_CLK_MHZ)
`define SMSP_SCL_KHZ 100
`define SMSP_QUARTER_CYC ((`SMSP_CLK_MHZ * 1000) / (4 * `SMSP_SCL_KHZ))

`endif

// ===== testbench/smsp_bench.sv
// Purpose: bench joining master and slave ends over the link
// Assumes: short quarter count; commit long enough to poll while busy
// Notes: a wire monitor keeps each address byte with its ack bit
`timescale 1ns/1ps

module smsp_bench;
	localparam logic [2:0] SEL = 3'h5;
	localparam logic [7:0] DEV_WR = {4'ha, SEL, 1'b0};
	localparam logic [7:0] DEV_RD = {4'ha, SEL, 1'b1};
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_read = 1'b0;
	logic cmd_set_addr = 1'b0;
	logic [2:0] cmd_sel = 3'h0;
	logic [7:0] cmd_addr = 8'h00;
	logic [3:0] cmd_len = 4'h0;
	logic wr_valid = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic rd_ready = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [2:0] pins = SEL;
	logic cmd_ready, wr_ready, rd_valid, done, nack_err, busy;
	logic [7:0] rd_data, cfg_rdata;
	logic [7:0] wq[8];
	logic [7:0] rq[8];
	logic done_seen = 1'b0;
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	logic in_addr = 1'b0;
	logic [3:0] bit_n = 4'h0;
	logic [8:0] sh = 9'h000;
	logic [8:0] addr_seen[$];
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;

	// ----------------------------------------
	// Ends and checker
	// ----------------------------------------
	smsp_link_if link();
	smsp_master #(.QUARTER_CYCLES(8)) smsp_master_inst (.link(link), .core_clk(core_clk),
		.sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
		.cmd_set_addr(cmd_set_addr), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_data(rd_data), .done(done), .nack_err(nack_err));
	// Long commit so a poll lands inside it
	smsp_slave #(.TW_CYCLES(600)) smsp_slave_inst (.link(link), .core_clk(core_clk),
		.sys_rst(sys_rst), .dev_select_bit0(pins[0]), .dev_select_bit1(pins[1]),
		.dev_select_bit2(pins[2]), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .busy(busy));
	smsp_properties smsp_properties_inst (.core_clk(core_clk), .sys_rst(sys_rst), .scl(link.scl),
		.m_sda_o(link.m_sda_o), .m_sda_oe_n(link.m_sda_oe_n), .s_sda_o(link.s_sda_o),
		.s_sda_oe_n(link.s_sda_oe_n), .sda_line(link.sda_line));

	// Clock of 20 ns
	always #10 core_clk = ~core_clk;

	// Watchdog and sticky end-of-transfer flag
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (done === 1'b1) begin
			done_seen <= 1'b1;
		end
		if (cycles == 30000) begin
			errors++;
			stop_test();
		end
	end

	// Wire monitor: address byte and ack after every start
	always @(posedge core_clk) begin
		scl_q <= link.scl;
		sda_q <= link.sda_line;
		if (link.scl && scl_q && sda_q && !link.sda_line) begin
			in_addr <= 1'b1;
			bit_n <= 4'h0;
		end else if (in_addr && link.scl && !scl_q) begin
			sh <= {sh[7:0], link.sda_line};
			bit_n <= bit_n + 4'h1;
			if (bit_n == 4'h8) begin
				addr_seen.push_back({sh[7:0], link.sda_line});
				in_addr <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR time %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR time %0t flag %h expected %h", $time, got, exp);
		end
	endtask

	// Empty queue yields a word no test expects
	task automatic chk_addr(input logic [7:0] exp, input logic ack);
		logic [8:0] w;
		w = (addr_seen.size() > 0) ? addr_seen.pop_front() : 9'h1ff;
		check8(w[8:1], exp);
		check1(w[0], ack);
	endtask

	// One command; stall holds the first read word to fill the buffer
	task automatic xfer(input logic rd, input logic sa, input logic [2:0] sel,
		input logic [7:0] addr, input int len, input logic stall);
		int i;
		int n;
		done_seen = 1'b0;
		cmd_valid = 1'b1;
		cmd_read = rd;
		cmd_set_addr = sa;
		cmd_sel = sel;
		cmd_addr = addr;
		cmd_len = 4'(len);
		@(negedge core_clk);
		cmd_valid = 1'b0;
		for (i = 0; i < len; i++) begin
			if (!rd) begin
				for (n = 0; n < 3000 && !wr_ready && !done_seen; n++) @(negedge core_clk);
				if (!wr_ready) break;
				wr_valid = 1'b1;
				wr_data = wq[i];
				@(negedge core_clk);
				wr_valid = 1'b0;
			end else begin
				for (n = 0; n < 3000 && !rd_valid && !done_seen; n++) @(negedge core_clk);
				if (!rd_valid) break;
				if (stall && i == 0) begin
					repeat (1500) @(negedge core_clk);
					check1(done_seen, 1'b0);
				end
				rq[i] = rd_data;
				rd_ready = 1'b1;
				@(negedge core_clk);
				rd_ready = 1'b0;
				@(negedge core_clk);
			end
		end
		for (n = 0; n < 3000 && !done_seen; n++) @(negedge core_clk);
	endtask

	// Wait out a row commit
	task automatic settle();
		int n;
		repeat (16) @(negedge core_clk);
		for (n = 0; n < 2000 && busy !== 1'b0; n++) @(negedge core_clk);
	endtask

	task automatic peek(input logic [7:0] a, input logic [7:0] exp);
		cfg_addr = a;
		repeat (2) @(negedge core_clk);
		check8(cfg_rdata, exp);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_write();
		int i;
		for (i = 0; i < 8; i++) wq[i] = 8'ha0 + 8'(i);
		xfer(1'b0, 1'b0, SEL, 8'h08, 8, 1'b0);
		chk_addr(DEV_WR, 1'b0);
		check1(nack_err, 1'b0);
		settle();
		wq[0] = 8'h11;
		wq[1] = 8'h22;
		wq[2] = 8'h33;
		xfer(1'b0, 1'b0, SEL, 8'h0e, 3, 1'b0);
		chk_addr(DEV_WR, 1'b0);
		xfer(1'b1, 1'b1, SEL, 8'h08, 1, 1'b0);
		chk_addr(DEV_WR, 1'b1);
		check1(nack_err, 1'b1);
		check1(busy, 1'b1);
		settle();
		peek(8'h08, 8'h33);
		for (i = 1; i < 6; i++) peek(8'h08 + 8'(i), 8'ha0 + 8'(i));
		peek(8'h0e, 8'h11);
		peek(8'h0f, 8'h22);
		$display("test write finished");
	endtask

	task automatic test_reads();
		xfer(1'b1, 1'b1, SEL, 8'h08, 1, 1'b0);
		chk_addr(DEV_WR, 1'b0);
		chk_addr(DEV_RD, 1'b0);
		check8(rq[0], 8'h33);
		check1(done_seen, 1'b1);
		check1(cmd_ready, 1'b1);
		xfer(1'b1, 1'b1, SEL, 8'h0b, 3, 1'b1);
		chk_addr(DEV_WR, 1'b0);
		chk_addr(DEV_RD, 1'b0);
		check8(rq[0], 8'ha3);
		check8(rq[1], 8'ha4);
		check8(rq[2], 8'ha5);
		xfer(1'b1, 1'b0, SEL, 8'h00, 2, 1'b0);
		chk_addr(DEV_RD, 1'b0);
		check8(rq[0], 8'h11);
		check8(rq[1], 8'h22);
		$display("test reads finished");
	endtask

	task automatic test_select();
		xfer(1'b1, 1'b0, 3'h2, 8'h00, 1, 1'b0);
		chk_addr({4'ha, 3'h2, 1'b1}, 1'b1);
		check1(nack_err, 1'b1);
		pins = 3'h2;
		repeat (4) @(negedge core_clk);
		xfer(1'b1, 1'b1, 3'h2, 8'h0f, 1, 1'b0);
		chk_addr({4'ha, 3'h2, 1'b0}, 1'b0);
		chk_addr({4'ha, 3'h2, 1'b1}, 1'b0);
		check8(rq[0], 8'h22);
		$display("test select finished");
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Main sequence: reset, idle line for the slave, then scenarios
	initial begin
		repeat (12) @(negedge core_clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge core_clk);
		test_write();
		test_reads();
		test_select();
		stop_test();
	end
endmodule

// ===== testbench/smsp_properties.sv
// Purpose: link checks between the master end and the slave end
// Assumes: quarter count of at least 8 core cycles on the master
// Notes: the slave reacts about 3 to 4 cycles after a link clock fall
`timescale 1ns/1ps

module smsp_properties (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic scl,
	input wire logic m_sda_o,
	input wire logic m_sda_oe_n,
	input wire logic s_sda_o,
	input wire logic s_sda_oe_n,
	input wire logic sda_line
);
	// ----------------------------------------
	// Link properties
	// ----------------------------------------
	// One domain, so clock and reset are given once
	default clocking link_clk @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// Slave may only move its data while the clock is low
	slave_steady_high_a: assert property (
		scl && $past(scl) |-> $stable(s_sda_oe_n)) else $error("slave data moved with clock high");
	// Pulling low follows a clock fall closely, never a rise
	slave_drive_time_a: assert property (
		$fell(s_sda_oe_n) |-> !$past(scl, 2) && $past(scl, 6)) else $error("slave drive off time");
	// Release also follows a fall, so the ack spans one bit
	slave_release_time_a: assert property (
		$rose(s_sda_oe_n) |-> !scl && $past(scl, 6)) else $error("slave release off time");
	// Both ends are open drain, never driving a high level
	open_drain_a: assert property (
		!m_sda_o && !s_sda_o) else $error("data driven high");
	// A start is the master's alone
	start_free_a: assert property (
		$fell(sda_line) && scl && $past(scl) |-> s_sda_oe_n) else $error("slave made a start");
	// Each bit keeps the clock high for at least eight core cycles
	clock_high_min_a: assert property (
		$rose(scl) |-> scl [*8]) else $error("link clock high too short");
	// Low half long enough for the slave to settle its bit
	clock_low_min_a: assert property (
		$fell(scl) |-> !scl [*8]) else $error("link clock low too short");
	// A start is followed by the address byte's clocks
	start_then_byte_a: assert property (
		scl && $past(scl) && $fell(m_sda_oe_n) |-> ##[1:20] !scl) else $error("no clock after start");
	// After a stop the clock rests high
	stop_idle_a: assert property (
		scl && $past(scl) && $rose(m_sda_oe_n) |-> scl [*8]) else $error("clock moved after stop");
endmodule

// ===== verilog/smsp_master.sv
// Purpose: master end, runs write and read transfers on the link
// Assumes: one command at a time; slave data line is asynchronous
// Notes: read bytes pass a two-entry buffer; a full buffer stalls the clock
`timescale 1ns/1ps
`include "smsp_regs.svh"

module smsp_master #(
	parameter int unsigned QUARTER_CYCLES = `SMSP_QUARTER_CYC
) (
	smsp_link_if.master link,
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_read,
	input wire logic cmd_set_addr,
	input wire logic [2:0] cmd_sel,
	input wire logic [7:0] cmd_addr,
	input wire logic [3:0] cmd_len,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [7:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [7:0] rd_data,
	output logic done,
	output logic nack_err
);

	smsp_pkg::smsp_mst_state_t r_reg;
	smsp_pkg::smsp_mst_state_t r_next;
	logic tick;
	logic pop;
	logic stall;
	logic tx;

	// Byte count: zero means one, a write never exceeds one row
	function automatic logic [3:0] clamp_len(input logic rd, input logic [3:0] len);
		clamp_len = (len == 4'h0) ? 4'h1 : len;
		if (!rd && len > 4'h8) begin
			clamp_len = 4'h8;
		end
	endfunction

	assign tick = (r_reg.q == 8'h00);
	assign pop = r_reg.rd_valid & rd_ready;
	assign tx = (r_reg.step != smsp_pkg::SMSP_M_RDATA);
	assign stall = r_reg.ph == 2'd0 && r_reg.bitn == 4'h0 &&
		((r_reg.step == smsp_pkg::SMSP_M_WDATA && !r_reg.loaded) ||
		(r_reg.step == smsp_pkg::SMSP_M_RDATA && r_reg.rcnt == 2'd2 && !pop));

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.sda_s1 = link.sda_line;
		r_next.sda_s2 = r_reg.sda_s1;
		r_next.q = tick ? 8'(QUARTER_CYCLES - 1) : r_reg.q - 8'h01;
		r_next.done = 1'b0;
		if (pop) begin
			r_next.rrp = ~r_reg.rrp;
			r_next.rcnt = r_next.rcnt - 2'd1;
		end
		// Write data handshake ahead of each data byte
		if (r_reg.wr_ready && wr_valid) begin
			r_next.sh = wr_data;
			r_next.loaded = 1'b1;
			r_next.wr_ready = 1'b0;
		end
		unique case (r_reg.step)
			smsp_pkg::SMSP_M_IDLE: begin
				if (cmd_valid && r_reg.cmd_ready) begin
					r_next.cmd_ready = 1'b0;
					r_next.nack_err = 1'b0;
					r_next.rd = cmd_read;
					r_next.set_addr = cmd_set_addr | ~cmd_read;
					r_next.sel = cmd_sel;
					r_next.addr = cmd_addr;
					r_next.left = clamp_len(cmd_read, cmd_len);
					r_next.step = smsp_pkg::SMSP_M_START;
					r_next.ph = 2'd0;
				end
			end
			smsp_pkg::SMSP_M_START, smsp_pkg::SMSP_M_RSTART: begin
				// Release, clock high, pull data low, clock low
				if (tick) begin
					r_next.ph = r_reg.ph + 2'd1;
					unique case (r_reg.ph)
						2'd0: r_next.sda_oe_n = 1'b1;
						2'd1: r_next.scl = 1'b1;
						2'd2: r_next.sda_oe_n = 1'b0;
						default: begin
							r_next.scl = 1'b0;
							r_next.bitn = 4'h0;
							// Address byte: fixed code, select bits, direction
							if (r_reg.step == smsp_pkg::SMSP_M_START) begin
								r_next.step = smsp_pkg::SMSP_M_DEV;
								r_next.sh = {`SMSP_DEV_CODE, r_reg.sel, ~r_reg.set_addr};
							end else begin
								r_next.step = smsp_pkg::SMSP_M_DEVR;
								r_next.sh = {`SMSP_DEV_CODE, r_reg.sel, 1'b1};
							end
						end
					endcase
				end
			end
			smsp_pkg::SMSP_M_STOP: begin
				if (tick) begin
					r_next.ph = r_reg.ph + 2'd1;
					unique case (r_reg.ph)
						2'd0: r_next.sda_oe_n = 1'b0;
						2'd1: r_next.scl = 1'b1;
						2'd2: r_next.sda_oe_n = 1'b1;
						default: begin
							r_next.step = smsp_pkg::SMSP_M_IDLE;
							r_next.done = 1'b1;
							r_next.cmd_ready = 1'b1;
						end
					endcase
				end
			end
			default: begin
				// Nine-bit byte slot, four quarters per bit
				if (tick && !stall) begin
					r_next.ph = r_reg.ph + 2'd1;
					unique case (r_reg.ph)
						2'd0: begin
							if (r_reg.bitn != 4'h8) begin
								r_next.sda_oe_n = tx ? r_reg.sh[7] : 1'b1;
							end else begin
								// Ack wanted bytes, nack the last one
								r_next.sda_oe_n = tx ? 1'b1 : (r_reg.left == 4'h1);
							end
						end
						2'd1: r_next.scl = 1'b1;
						2'd2: begin
							if (r_reg.bitn != 4'h8) begin
								r_next.sh = {r_reg.sh[6:0], r_reg.sda_s2};
							end else begin
								r_next.ack = ~r_reg.sda_s2;
							end
						end
						default: begin
							r_next.scl = 1'b0;
							r_next.bitn = r_reg.bitn + 4'h1;
							if (r_reg.bitn == 4'h8) begin
								r_next.bitn = 4'h0;
								r_next.sda_oe_n = 1'b1;
								if (tx && !r_reg.ack) begin
									r_next.nack_err = 1'b1;
									r_next.step = smsp_pkg::SMSP_M_STOP;
								end else begin
									unique case (r_reg.step)
										smsp_pkg::SMSP_M_DEV: begin
											if (r_reg.set_addr) begin
												r_next.step = smsp_pkg::SMSP_M_MADDR;
												r_next.sh = r_reg.addr;
											end else begin
												r_next.step = smsp_pkg::SMSP_M_RDATA;
											end
										end
										smsp_pkg::SMSP_M_MADDR: begin
											if (r_reg.rd) begin
												r_next.step = smsp_pkg::SMSP_M_RSTART;
											end else begin
												r_next.step = smsp_pkg::SMSP_M_WDATA;
												r_next.loaded = 1'b0;
												r_next.wr_ready = 1'b1;
											end
										end
										smsp_pkg::SMSP_M_WDATA: begin
											if (r_reg.left == 4'h1) begin
												r_next.step = smsp_pkg::SMSP_M_STOP;
											end else begin
												r_next.left = r_reg.left - 4'h1;
												r_next.loaded = 1'b0;
												r_next.wr_ready = 1'b1;
											end
										end
										smsp_pkg::SMSP_M_DEVR: r_next.step = smsp_pkg::SMSP_M_RDATA;
										default: begin
											r_next.rbuf[r_reg.rwp] = r_reg.sh;
											r_next.rwp = ~r_reg.rwp;
											r_next.rcnt = r_next.rcnt + 2'd1;
											r_next.left = r_reg.left - 4'h1;
											if (r_reg.left == 4'h1) begin
												r_next.step = smsp_pkg::SMSP_M_STOP;
											end
										end
									endcase
								end
							end
						end
					endcase
				end
			end
		endcase
		r_next.rd_valid = (r_next.rcnt != 2'd0);
		r_next.rd_data = r_next.rbuf[r_next.rrp];
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r_reg <= '0;
			r_reg.scl <= 1'b1;
			r_reg.sda_oe_n <= 1'b1;
			r_reg.cmd_ready <= 1'b1;
			r_reg.sda_s1 <= 1'b1;
			r_reg.sda_s2 <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign link.scl = r_reg.scl;
	assign link.m_sda_o = 1'b0;
	assign link.m_sda_oe_n = r_reg.sda_oe_n;
	assign cmd_ready = r_reg.cmd_ready;
	assign wr_ready = r_reg.wr_ready;
	assign rd_valid = r_reg.rd_valid;
	assign rd_data = r_reg.rd_data;
	assign done = r_reg.done;
	assign nack_err = r_reg.nack_err;

endmodule

// ===== verilog/smsp_slave.sv
// Purpose: slave end, serves an on-chip config memory over the link
// Assumes: link pins and select pins are asynchronous to core_clk
// Notes: written rows are committed after stop; busy while committing
`timescale 1ns/1ps
`include "smsp_regs.svh"

module smsp_slave #(
	parameter int unsigned TW_CYCLES = `SMSP_TW_CYC
) (
	smsp_link_if.slave link,
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic dev_select_bit0,
	input wire logic dev_select_bit1,
	input wire logic dev_select_bit2,
	input wire logic [`SMSP_ADDR_W-1:0] cfg_addr,
	output logic [7:0] cfg_rdata,
	output logic busy
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	smsp_pkg::smsp_slv_t r_reg;
	smsp_pkg::smsp_slv_t r_next;
	logic [7:0] mem [0:(1 << `SMSP_ADDR_W) - 1];
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	// Byte at a memory location
	function automatic logic [7:0] rd_byte(input logic [7:0] a);
		rd_byte = mem[a];
	endfunction

	// Line events, taken from the second and third stages only
	assign scl_rise = r_reg.scl_s2 & ~r_reg.scl_s3;
	assign scl_fall = ~r_reg.scl_s2 & r_reg.scl_s3;
	assign start_seen = r_reg.scl_s2 & r_reg.scl_s3 & r_reg.sda_s3 & ~r_reg.sda_s2;
	assign stop_seen = r_reg.scl_s2 & r_reg.scl_s3 & ~r_reg.sda_s3 & r_reg.sda_s2;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.scl_s1 = link.scl;
		r_next.scl_s2 = r_reg.scl_s1;
		r_next.scl_s3 = r_reg.scl_s2;
		r_next.sda_s1 = link.sda_line;
		r_next.sda_s2 = r_reg.sda_s1;
		r_next.sda_s3 = r_reg.sda_s2;
		r_next.sel_s1 = {dev_select_bit2, dev_select_bit1, dev_select_bit0};
		r_next.sel_s2 = r_reg.sel_s1;
		r_next.cfg_rdata = rd_byte(cfg_addr);
		r_next.commit = 1'b0;
		// Commit timer; the row goes to storage on its last count
		if (r_reg.busy_cnt != 16'h0000) begin
			r_next.busy_cnt = r_reg.busy_cnt - 16'h0001;
			r_next.commit = (r_reg.busy_cnt == 16'h0001);
		end
		if (start_seen) begin
			// Start or repeated start always re-arms address reception
			r_next.st = smsp_pkg::SMSP_S_RX;
			r_next.kind = smsp_pkg::SMSP_K_DEV;
			r_next.cnt = 4'h0;
			r_next.sda_oe_n = 1'b1;
		end else if (stop_seen) begin
			r_next.st = smsp_pkg::SMSP_S_IDLE;
			r_next.sda_oe_n = 1'b1;
			if (r_reg.dirty) begin
				r_next.dirty = 1'b0;
				r_next.busy_cnt = 16'(TW_CYCLES);
			end
		end else begin
			unique case (r_reg.st)
				smsp_pkg::SMSP_S_IDLE: begin
					r_next.sda_oe_n = 1'b1;
				end
				smsp_pkg::SMSP_S_RX: begin
					if (scl_rise && r_reg.cnt != 4'h8) begin
						r_next.sh = {r_reg.sh[6:0], r_reg.sda_s2};
						r_next.cnt = r_reg.cnt + 4'h1;
					end else if (scl_fall && r_reg.cnt == 4'h8) begin
						r_next.st = smsp_pkg::SMSP_S_RX_ACK;
						r_next.sda_oe_n = 1'b0;
						unique case (r_reg.kind)
							smsp_pkg::SMSP_K_DEV: begin
								// Foreign address, or busy committing: stay off the line
								if (r_reg.sh[7:4] != `SMSP_DEV_CODE ||
									r_reg.sh[3:1] != r_reg.sel_s2 ||
									r_reg.busy_cnt != 16'h0000) begin
									r_next.st = smsp_pkg::SMSP_S_IDLE;
									r_next.sda_oe_n = 1'b1;
								end
								r_next.rw = r_reg.sh[0];
							end
							smsp_pkg::SMSP_K_MADDR: begin
								// Dummy write sets the counter; open the row image
								r_next.addr = r_reg.sh;
								r_next.wrow = r_reg.sh[7:3];
								for (int i = 0; i < `SMSP_ROW_BYTES; i++) begin
									r_next.row_buf[i] = rd_byte({r_reg.sh[7:3], 3'(i)});
								end
							end
							default: begin
								r_next.row_buf[r_reg.addr[2:0]] = r_reg.sh;
								r_next.dirty = 1'b1;
								// Counter stays in the row, wrapping to its first byte
								r_next.addr = {r_reg.addr[7:3], r_reg.addr[2:0] + 3'h1};
							end
						endcase
					end
				end
				smsp_pkg::SMSP_S_RX_ACK: begin
					if (scl_fall) begin
						r_next.cnt = 4'h0;
						if (r_reg.kind == smsp_pkg::SMSP_K_DEV && r_reg.rw) begin
							// Read from wherever the counter stands
							r_next.st = smsp_pkg::SMSP_S_TX;
							r_next.sh = rd_byte(r_reg.addr);
							r_next.sda_oe_n = rd_byte(r_reg.addr) >> 7 != 8'h00;
						end else begin
							r_next.st = smsp_pkg::SMSP_S_RX;
							r_next.sda_oe_n = 1'b1;
							r_next.kind = (r_reg.kind == smsp_pkg::SMSP_K_DEV) ?
								smsp_pkg::SMSP_K_MADDR : smsp_pkg::SMSP_K_DATA;
						end
					end
				end
				smsp_pkg::SMSP_S_TX: begin
					if (scl_fall) begin
						if (r_reg.cnt == 4'h7) begin
							r_next.st = smsp_pkg::SMSP_S_TX_ACK;
							r_next.sda_oe_n = 1'b1;
						end else begin
							r_next.sh = {r_reg.sh[6:0], 1'b0};
							r_next.sda_oe_n = r_reg.sh[6];
							r_next.cnt = r_reg.cnt + 4'h1;
						end
					end
				end
				smsp_pkg::SMSP_S_TX_ACK: begin
					if (scl_rise) begin
						r_next.mack = ~r_reg.sda_s2;
					end else if (scl_fall) begin
						// Counter advances past every byte handed out
						r_next.addr = r_reg.addr + 8'h01;
						r_next.cnt = 4'h0;
						if (r_reg.mack) begin
							r_next.st = smsp_pkg::SMSP_S_TX;
							r_next.sh = rd_byte(r_reg.addr + 8'h01);
							r_next.sda_oe_n = rd_byte(r_reg.addr + 8'h01) >> 7 != 8'h00;
						end else begin
							// Not acknowledged: hand the line back and wait for stop
							r_next.st = smsp_pkg::SMSP_S_IDLE;
							r_next.sda_oe_n = 1'b1;
						end
					end
				end
				default: begin
					r_next.st = smsp_pkg::SMSP_S_IDLE;
					r_next.sda_oe_n = 1'b1;
				end
			endcase
		end
		r_next.busy = (r_next.busy_cnt != 16'h0000) | r_next.commit;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r_reg <= '0;
			r_reg.sda_oe_n <= 1'b1;
			r_reg.scl_s1 <= 1'b1;
			r_reg.scl_s2 <= 1'b1;
			r_reg.scl_s3 <= 1'b1;
			r_reg.sda_s1 <= 1'b1;
			r_reg.sda_s2 <= 1'b1;
			r_reg.sda_s3 <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// Row commit: all eight bytes rewritten, unchanged ones from the image
	always_ff @(posedge core_clk) begin
		if (r_reg.commit) begin
			for (int i = 0; i < `SMSP_ROW_BYTES; i++) begin
				mem[{r_reg.wrow, 3'(i)}] <= r_reg.row_buf[i];
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign link.s_sda_o = 1'b0;
	assign link.s_sda_oe_n = r_reg.sda_oe_n;
	assign cfg_rdata = r_reg.cfg_rdata;
	assign busy = r_reg.busy;

endmodule
